// [core/denoise_lp_core.sv]
// Denoised signal rebuild by inverse transform and overlap-add, then LP autocorrelation
//
// Contract
// - Inverse transform each spectrum, normalised by length
// - Transform both analyses of every frame
// - Window each transform output by sqrt Hann
// - First half: previous upper plus first lower
// - Second half: first upper plus second lower
// - Keep second upper half for next frame
// - Lookahead: second upper half over window squared
// - Lookahead is provisional, replaced next frame
// - One LP analysis per frame, 30 ms window
// - First 256 coefficients half Hamming shape
// - Next 128 coefficients quarter cosine shape
// - Autocorrelate 384 windowed samples, lags 0..16
// - Gaussian lag window on lags 1..16
// - Zero lag floored at 100
// - Wideband zero lag times 1.0001
// - Narrowband zero lag times 1.0031
`timescale 1ns/1ps
`include "denoise_lp_map.svh"
module denoise_lp_core
   import denoise_lp_pkg::*;
#(
   parameter int N = 256
)
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire spec_word_t spec_in,
   input  wire logic       spec_valid_in,
   input  wire logic       nb_mode_in,
   output logic            spec_ready_out,
   output samp_t           s_out,
   output logic [8:0]      s_idx_out,
   output logic            s_valid_out,
   output logic            s_tail_out,
   output acorr_vec_t      r_out,
   output logic            r_valid_out
);
   //--------------------------------------------------
   // Constant tables
   //--------------------------------------------------
   localparam int         H       = N / 2;
   localparam int         LOGN    = $clog2(N);
   localparam int         LP_LEN  = `LP_WIN_MS * `FS_HZ / 1000;
   localparam logic [8:0] LP_LAST = 9'(LP_LEN - 1);
   localparam logic [8:0] H9      = 9'(H);
   localparam logic [8:0] N_LAST  = 9'(N - 1);
   localparam logic [8:0] MASK    = 9'(N - 1);
   localparam logic [8:0] QUART   = 9'(N / 4);
   localparam logic [8:0] SB_LEN  = 9'(3 * H);
   localparam real        PI      = 3.14159265358979;

   typedef samp_t       tab_n_t   [N];
   typedef logic [23:0] tab_inv_t [H];
   typedef samp_t       tab_lp_t  [LP_LEN];
   typedef samp_t       tab_lag_t [17];

   function automatic tab_n_t mk_cos();
      tab_n_t t;
      for (int i = 0; i < N; i++)
         t[i] = samp_t'($rtoi(`Q15_ONE * $cos(2.0 * PI * i / N)));
      return t;
   endfunction : mk_cos

   function automatic tab_n_t mk_hann();
      tab_n_t t;
      for (int i = 0; i < N; i++)
         t[i] = samp_t'($rtoi(`Q15_ONE * $sin(PI * i / N)));
      return t;
   endfunction : mk_hann

   function automatic tab_inv_t mk_invw();
      tab_inv_t t;
      real      s;
      for (int i = 0; i < H; i++)
      begin
         s    = $sin(PI * (i + H) / N);
         t[i] = 24'($rtoi((2.0 ** `INVW_FRAC) / (s * s)));
      end
      return t;
   endfunction : mk_invw

   function automatic tab_lp_t mk_lpw();
      tab_lp_t t;
      for (int i = 0; i < LP_LEN; i++)
         if (i < `LPW_L1)
            t[i] = samp_t'($rtoi(`Q15_ONE * (0.54 - 0.46 * $cos(2.0 * PI * i
                   / (2.0 * `LPW_L1 - 1.0)))));
         else
            t[i] = samp_t'($rtoi(`Q15_ONE * $cos(2.0 * PI * (i - `LPW_L1)
                   / (4.0 * `LPW_L2 - 1.0))));
      return t;
   endfunction : mk_lpw

   function automatic tab_lag_t mk_lag();
      tab_lag_t t;
      real      a;
      for (int i = 0; i < 17; i++)
      begin
         a    = 2.0 * PI * `LAG_F0_HZ * i / `LAG_FS_HZ;
         t[i] = samp_t'($rtoi(`Q15_ONE * $exp(-0.5 * a * a)));
      end
      return t;
   endfunction : mk_lag

   localparam tab_n_t   COS_TAB  = mk_cos();
   localparam tab_n_t   HANN_TAB = mk_hann();
   localparam tab_inv_t INVW_TAB = mk_invw();
   localparam tab_lp_t  LPW_TAB  = mk_lpw();
   localparam tab_lag_t LAG_TAB  = mk_lag();

   function automatic samp_t sat16(input acc_t v);
      if (v > acc_t'(32767))
         return 16'sh7fff;
      else if (v < -acc_t'(32768))
         return -16'sh8000;
      else
         return v[15:0];
   endfunction : sat16

   //--------------------------------------------------
   // Storage
   //--------------------------------------------------
   samp_t spec_re [N];
   samp_t spec_im [N];
   samp_t blk1_hi [H];
   samp_t prev_hi [H];
   samp_t sbuf    [LP_LEN];
   samp_t wbuf    [LP_LEN];

   core_state_t              q;
   core_state_t              nxt;
   acc_t                     term;
   acc_t                     xww_ext;
   samp_t                    xn;
   samp_t                    xww;
   samp_t                    prev_term;
   logic                     blk_we;
   logic                     prev_we;
   logic                     wb_we;
   samp_t                    wb_data;
   logic [8:0]               sin_idx;
   acc_t                     r0_fl;
   logic signed [65:0]       r0_prod;
   logic signed [63:0]       lag_prod;

   //--------------------------------------------------
   // Next-state logic
   //--------------------------------------------------
   always_comb
   begin
      nxt         = q;
      nxt.s_valid = 1'b0;
      nxt.r_valid = 1'b0;
      blk_we      = 1'b0;
      prev_we     = 1'b0;
      wb_we       = 1'b0;
      wb_data     = '0;
      r0_fl       = '0;
      r0_prod     = '0;
      lag_prod    = '0;
      sin_idx     = (q.tw - QUART) & MASK;
      term        = acc_t'(spec_re[q.k[LOGN-1:0]] * COS_TAB[q.tw[LOGN-1:0]])
                  - acc_t'(spec_im[q.k[LOGN-1:0]] * COS_TAB[sin_idx[LOGN-1:0]]);
      xn          = sat16(q.acc >>> (`Q15_SHIFT + LOGN));
      xww_ext     = acc_t'(xn * HANN_TAB[q.n[LOGN-1:0]]) >>> `Q15_SHIFT;
      xww         = sat16(xww_ext);
      prev_term   = q.prev_ok ? prev_hi[q.n[LOGN-2:0]] : 16'sh0000;
      case (q.state)
         ST_IDLE:
         begin
            if (spec_valid_in && q.ready && spec_in.last)
            begin
               nxt.state = ST_IDFT;
               nxt.ana   = spec_in.sel;
               nxt.nb    = nb_mode_in;
               nxt.n     = '0;
               nxt.k     = '0;
               nxt.tw    = '0;
               nxt.acc   = '0;
            end
         end
         ST_IDFT:
         begin
            nxt.acc = q.acc + term;
            nxt.k   = q.k + 9'h001;
            nxt.tw  = (q.tw + q.n) & MASK;
            if (q.k == N_LAST)
               nxt.state = ST_OUT;
         end
         ST_OUT:
         begin
            if (!q.ana)
            begin
               if (q.n < H9)
               begin
                  nxt.s_valid = 1'b1;
                  nxt.s_tail  = 1'b0;
                  nxt.s_idx   = `OLA_OFFSET + q.n;
                  nxt.s_val   = sat16(acc_t'(prev_term) + acc_t'(xww));
               end
               else
                  blk_we = 1'b1;
            end
            else
            begin
               nxt.s_valid = 1'b1;
               nxt.s_idx   = `OLA_OFFSET + H9 + q.n;
               if (q.n < H9)
               begin
                  nxt.s_tail = 1'b0;
                  nxt.s_val  = sat16(acc_t'(blk1_hi[q.n[LOGN-2:0]]) + acc_t'(xww));
               end
               else
               begin
                  prev_we    = 1'b1;
                  nxt.s_tail = 1'b1;
                  nxt.s_val  = sat16((acc_t'(xww) * acc_t'(INVW_TAB[q.n[LOGN-2:0]]))
                               >>> `INVW_FRAC);
               end
            end
            if (q.n == N_LAST)
            begin
               nxt.n = '0;
               if (q.ana)
               begin
                  nxt.state   = ST_WIN;
                  nxt.prev_ok = 1'b1;
               end
               else
                  nxt.state = ST_IDLE;
            end
            else
            begin
               nxt.n     = q.n + 9'h001;
               nxt.k     = '0;
               nxt.tw    = '0;
               nxt.acc   = '0;
               nxt.state = ST_IDFT;
            end
         end
         ST_WIN:
         begin
            wb_we   = 1'b1;
            // Positions the frame does not rebuild count as silence
            wb_data = (q.n < SB_LEN) ? sat16(acc_t'(sbuf[q.n] * LPW_TAB[q.n]) >>> `Q15_SHIFT)
                                     : 16'sh0000;
            nxt.n   = q.n + 9'h001;
            if (q.n == LP_LAST)
            begin
               nxt.state = ST_ACORR;
               nxt.n     = '0;
               nxt.k     = '0;
               nxt.acc   = '0;
            end
         end
         ST_ACORR:
         begin
            nxt.acc = q.acc + acc_t'(wbuf[q.n] * wbuf[q.n - q.k]);
            nxt.n   = q.n + 9'h001;
            if (q.n == LP_LAST)
            begin
               nxt.r_vec[q.k[4:0]] = q.acc + acc_t'(wbuf[q.n] * wbuf[q.n - q.k]);
               nxt.acc             = '0;
               nxt.k               = q.k + 9'h001;
               nxt.n               = q.k + 9'h001;
               if (q.k == `LAG_MAX)
                  nxt.state = ST_POST;
            end
         end
         ST_POST:
         begin
            r0_fl   = (q.r_vec[0] < `R0_FLOOR) ? `R0_FLOOR : q.r_vec[0];
            r0_prod = q.nb ? r0_fl * $signed({1'b0, `WNC_NB})
                           : r0_fl * $signed({1'b0, `WNC_WB});
            nxt.r_out[0] = acc_t'(r0_prod >>> `WNC_SHIFT);
            for (int i = 1; i <= 16; i++)
            begin
               lag_prod     = q.r_vec[i] * LAG_TAB[i];
               nxt.r_out[i] = acc_t'(lag_prod >>> `Q15_SHIFT);
            end
            nxt.r_valid = 1'b1;
            nxt.state   = ST_IDLE;
         end
         default:
            nxt.state = ST_IDLE;
      endcase
      nxt.ready = (nxt.state == ST_IDLE);
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q       <= '0;
         q.ready <= 1'b1;
      end
      else
         q <= nxt;
   end

   //--------------------------------------------------
   // Memory writes
   //--------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (spec_valid_in && q.ready)
      begin
         spec_re[spec_in.bin[LOGN-1:0]] <= spec_in.re;
         spec_im[spec_in.bin[LOGN-1:0]] <= spec_in.im;
      end
      if (blk_we)
         blk1_hi[q.n[LOGN-2:0]] <= xww;
      if (prev_we)
         prev_hi[q.n[LOGN-2:0]] <= xww;
      if (nxt.s_valid)
         sbuf[nxt.s_idx - `OLA_OFFSET] <= nxt.s_val;
      if (wb_we)
         wbuf[q.n] <= wb_data;
   end

   assign spec_ready_out = q.ready;
   assign s_out          = q.s_val;
   assign s_idx_out      = q.s_idx;
   assign s_valid_out    = q.s_valid;
   assign s_tail_out     = q.s_tail;
   assign r_out          = q.r_out;
   assign r_valid_out    = q.r_valid;

   //--------------------------------------------------
   // Assertions
   //--------------------------------------------------
   AST_R_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      r_valid_out |=> !r_valid_out [*8])
      else $error("result valid longer than one cycle");
   AST_R0_FLOOR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      r_valid_out |-> r_out[0] >= `R0_FLOOR)
      else $error("zero lag below floor");
   AST_R0_WB: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      q.state == ST_POST && !q.nb && q.r_vec[0] >= 48'sh10000
      |=> r_out[0] >= $past(q.r_vec[0])
          && r_out[0] <= $past(q.r_vec[0]) + ($past(q.r_vec[0]) >>> 9))
      else $error("wideband correction wrong");
   AST_R0_NB: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      q.state == ST_POST && q.nb && q.r_vec[0] >= 48'sh10000
      |=> r_out[0] > $past(q.r_vec[0]) + ($past(q.r_vec[0]) >>> 9))
      else $error("narrowband correction wrong");
   AST_TAIL_IDX: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_valid_out && s_tail_out |-> s_idx_out >= `OLA_OFFSET + 9'(N))
      else $error("lookahead sample placed inside overlap region");
   AST_PREV_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      q.state == ST_OUT && !q.ana && !q.prev_ok && q.n < H9
      |=> s_valid_out && s_out == $past(xww))
      else $error("stale previous block used after reset");
   // Cycles spent in the current transform or window pass, free of the loop indices
   logic [9:0] phase_cyc_ff;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         phase_cyc_ff <= '0;
      else if (q.state == ST_IDFT || q.state == ST_WIN)
         phase_cyc_ff <= phase_cyc_ff + 10'h001;
      else
         phase_cyc_ff <= '0;
   end
   AST_IDFT_LEN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      q.state == ST_OUT && $past(q.state) == ST_IDFT |-> phase_cyc_ff == 10'(N))
      else $error("inverse transform length wrong");
   AST_WIN_LEN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      q.state == ST_ACORR && $past(q.state) == ST_WIN
      |-> phase_cyc_ff == 10'(LP_LEN) && q.k == '0 && q.n == '0)
      else $error("window pass length wrong");
   AST_ONE_LP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      q.state == ST_OUT && q.ana && q.n == N_LAST |=> q.state == ST_WIN
      ##1 (!r_valid_out [*8]))
      else $error("LP analysis not entered once after second analysis");
endmodule : denoise_lp_core

// [common/denoise_lp_map.svh]
// Offsets, fixed-point figures and timing constants of the denoise/LP front end
`ifndef DENOISE_LP_MAP_SVH
`define DENOISE_LP_MAP_SVH
`define OLA_OFFSET    9'h018
`define LP_WIN_MS     30
`define LP_OVH_MS     5
`define FS_HZ         12800
`define LAG_F0_HZ     60.0
`define LAG_FS_HZ     12800.0
`define LPW_L1        256
`define LPW_L2        128
`define LAG_MAX       9'h010
`define R0_FLOOR      48'h000000000064
`define WNC_WB        17'h10007
`define WNC_NB        17'h100cb
`define WNC_SHIFT     16
`define Q15_SHIFT     15
`define INVW_FRAC     10
`define Q15_ONE       32767.0
`endif

// [common/denoise_lp_pkg.sv]
// Types shared by the denoise overlap-add and LP autocorrelation core
package denoise_lp_pkg;
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_IDFT  = 3'b001,
      ST_OUT   = 3'b010,
      ST_WIN   = 3'b011,
      ST_ACORR = 3'b100,
      ST_POST  = 3'b101
   } fsm_t;
   typedef logic signed [15:0] samp_t;
   typedef logic signed [47:0] acc_t;
   typedef acc_t [16:0]        acorr_vec_t;
   typedef struct packed
   {
      logic       sel;
      logic       last;
      logic [8:0] bin;
      samp_t      re;
      samp_t      im;
   } spec_word_t;
   typedef struct packed
   {
      fsm_t       state;
      logic       ana;
      logic [8:0] n;
      logic [8:0] k;
      logic [8:0] tw;
      acc_t       acc;
      logic       prev_ok;
      logic       nb;
      logic       ready;
      samp_t      s_val;
      logic [8:0] s_idx;
      logic       s_valid;
      logic       s_tail;
      acorr_vec_t r_vec;
      acorr_vec_t r_out;
      logic       r_valid;
   } core_state_t;
endpackage : denoise_lp_pkg

// [testbench/spectrum_source.sv]
// Upstream spectrum source model feeding the denoise core
`timescale 1ns/1ps
module spectrum_source
   import denoise_lp_pkg::*;
#(
   parameter int N = 64
)
(
   input  wire logic  clk_in,
   input  wire logic  ready_in,
   output spec_word_t word_out,
   output logic       valid_out,
   output logic       nb_out
);
   initial
   begin
      word_out  = '0;
      valid_out = 1'b0;
      nb_out    = 1'b0;
   end

   // Spectrum with DC in bin 0, bin 1 left out when skip1 is set; each word held until accepted
   task automatic send(input logic sel, input samp_t amp, input logic nb, input logic skip1);
      @(posedge clk_in);
      for (int b = 0; b < N; b++)
      begin
         if (!(skip1 && b == 1))
         begin
            word_out  <= '{sel, b == N - 1, 9'(b), (b == 0) ? amp : 16'sh0000, 16'sh0000};
            nb_out    <= nb;
            valid_out <= 1'b1;
            do @(posedge clk_in); while (ready_in !== 1'b1);
         end
      end
      valid_out <= 1'b0;
      word_out  <= spec_word_t'(~word_out);
   endtask : send

   // One word offered while the core is busy
   task automatic poke(input samp_t val);
      @(posedge clk_in);
      word_out  <= '{1'b0, 1'b0, 9'h001, val, val};
      valid_out <= 1'b1;
      @(posedge clk_in);
      valid_out <= 1'b0;
      word_out  <= spec_word_t'(~word_out);
   endtask : poke
endmodule : spectrum_source

// [testbench/tb_denoise_lp_core.sv]
// Self-checking bench of the denoise overlap-add and LP autocorrelation core
`timescale 1ns/1ps
module tb_denoise_lp_core
   import denoise_lp_pkg::*;
;
   localparam int N = 64;
   localparam int H = N / 2;
   typedef struct {int amp; bit nb; bit prev; int r0;} row_t;
   // Rows: DC amplitude, narrowband, previous block live, expected r0 (-1 relational)
   row_t       rows [4] = '{'{0, 0, 0, 100}, '{32000, 0, 0, -1}, '{32000, 0, 1, -1},
                            '{32000, 1, 1, -1}};
   logic       clk_in;
   logic       rst_n_in;
   spec_word_t spec_w;
   logic       spec_v;
   logic       nb_w;
   logic       ready;
   samp_t      s_val;
   logic [8:0] s_idx;
   logic       s_v;
   logic       s_tail;
   acorr_vec_t r_vec;
   acorr_vec_t r_seen;
   logic       r_v;
   int         failures = 0;
   int         checks_done = 0;
   int         n_samp;
   int         n_rv;
   int         cur_amp;
   real        cur_prev;
   longint     wb_r0;
   bit         acc_last = 0;

   spectrum_source #(.N(N)) src_u (.clk_in(clk_in), .ready_in(ready), .word_out(spec_w),
      .valid_out(spec_v), .nb_out(nb_w));
   denoise_lp_core #(.N(N)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .spec_in(spec_w),
      .spec_valid_in(spec_v), .nb_mode_in(nb_w), .spec_ready_out(ready), .s_out(s_val),
      .s_idx_out(s_idx), .s_valid_out(s_v), .s_tail_out(s_tail), .r_out(r_vec),
      .r_valid_out(r_v));

   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   function automatic real sw(input int i);
      return $sin(3.141592653589793 * i / N);
   endfunction : sw

   // Sample at frame position p for a DC spectrum
   function automatic real exp_samp(input int p);
      real x;
      x = real'(cur_amp) / N;
      if (p < H)
         return x * (cur_prev * sw(p + H) + sw(p));
      if (p < N)
         return x * (sw(p) + sw(p - H));
      return x / sw(p - H);
   endfunction : exp_samp

   function automatic bit near(input samp_t s, input real e);
      real d;
      if ($isunknown(s))
         return 1'b0;
      d = real'(s) - e;
      return (d < 0 ? -d : d) <= 4.0 + (e < 0 ? -e : e) / 32.0;
   endfunction : near

   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   // ----------------------------------------
   // Output monitor
   // ----------------------------------------
   always @(posedge clk_in)
   begin
      if (rst_n_in && acc_last)
         check("ready_drop", ready, 0);
      acc_last <= rst_n_in && spec_v && ready && spec_w.last;
      if (rst_n_in && s_v === 1'b1)
      begin
         check("s_idx", s_idx, 24 + n_samp);
         check("s_tail", s_tail, n_samp >= N);
         check("s_val", near(s_val, exp_samp(n_samp)), 1);
         n_samp++;
      end
      if (rst_n_in && r_v === 1'b1)
      begin
         check("ready_at_result", ready, 1);
         r_seen = r_vec;
         n_rv++;
      end
   end

   task automatic run_frame(input int amp, input bit nb, input bit prev, input int r0,
                            input bit poke1);
      int     t;
      longint d;
      cur_amp  = amp;
      cur_prev = prev;
      n_samp   = 0;
      n_rv     = 0;
      src_u.send(1'b0, samp_t'(amp), nb, 1'b0);
      if (poke1)
         src_u.poke(16'sh7fff);
      src_u.send(1'b1, samp_t'(amp), nb, poke1);
      t = 0;
      while (n_rv == 0 && t < 20000)
      begin
         @(posedge clk_in);
         t++;
      end
      repeat (2) @(posedge clk_in);
      check("samples", n_samp, 3 * H);
      check("results", n_rv, 1);
      if (r0 >= 0)
         for (int k = 0; k < 17; k++)
            check("r_lag", r_seen[k], k == 0 ? r0 : 0);
      else if (!poke1)
      begin
         for (int k = 1; k < 17; k++)
            check("r_bound", r_seen[k] <= r_seen[0] && -r_seen[k] <= r_seen[0], 1);
         if (nb)
         begin
            d = r_seen[0] - wb_r0 * 65739 / 65543;
            check("r0_nb", d >= -2 && d <= 2 && r_seen[0] > wb_r0, 1);
         end
         else
            wb_r0 = r_seen[0];
      end
   endtask : run_frame

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rst_n_in = 1'b0;
      repeat (16) @(posedge clk_in);
      check("rst_ready", ready, 1);
      check("rst_out", |{s_v, r_v, s_tail, s_idx, s_val, r_vec}, 0);
      rst_n_in <= 1'b1;
      foreach (rows[i])
         run_frame(rows[i].amp, rows[i].nb, rows[i].prev, rows[i].r0, 1'b0);
      // Reset after live frames, then a word refused while busy
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      run_frame(32000, 1'b0, 1'b0, -1, 1'b1);
      final_report();
   end

   initial
   begin
      repeat (100000) @(posedge clk_in);
      failures++;
      final_report();
   end
endmodule : tb_denoise_lp_core
